// *** rfs_phase_model.sv ***
// Behavioural far side of the supervisor: oscillator ticks, the phase chip chain and share bus.
// Assumes the supervisor launches the chain with a pulse of at least one clock.
`timescale 1ns/100ps
module rfs_phase_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic phase_chain_out,
  input wire logic current_share_node_force,
  input wire logic [4:0] n_phases,
  input wire logic chain_open,
  output logic oscillator_pulse,
  output logic phase_chain_in,
  output logic low_side_on
);
  logic [2:0] div_r;
  logic [4:0] cnt_r;
  logic [1:0] hold_r;
  logic busy_r;
  // ==========================================================================
  // Chain and share bus
  // ==========================================================================
  // Low side switches stay on for as long as the share bus sits at the supply.
  assign low_side_on = current_share_node_force;
  assign oscillator_pulse = div_r[2];
  assign phase_chain_in = (hold_r != 2'h0);
  // The return is held three clocks so it survives the two-stage synchroniser.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= 3'h0;
      cnt_r <= 5'h00;
      hold_r <= 2'h0;
      busy_r <= 1'h0;
    end else begin
      div_r <= div_r + 3'h1;
      if (hold_r != 2'h0) begin
        hold_r <= hold_r - 2'h1;
      end
      if (phase_chain_out) begin
        busy_r <= 1'h1;
        cnt_r <= 5'h00;
      end else if (busy_r && div_r == 3'h3) begin
        cnt_r <= cnt_r + 5'h01;
      end else if (busy_r && div_r == 3'h5 && cnt_r == n_phases && !chain_open) begin
        busy_r <= 1'h0;
        hold_r <= 2'h3;
      end
    end
  end
endmodule : rfs_phase_model

// *** rfs_pkg.sv ***
// Constants, state layout and register map of the regulator fault supervisor.
// Assumes one 100 MHz clock and comparator results already in digital form.
package rfs_pkg;

  // ==========================================================================
  // Timing counts, in oscillator pulses
  // ==========================================================================
  localparam logic [10:0] OCP_TICKS = 11'h400;
  localparam logic [10:0] OCP_LAST = OCP_TICKS - 11'h001;
  localparam logic [3:0] EAMP_TICKS = 4'h8;
  localparam logic [3:0] EAMP_LAST = EAMP_TICKS - 4'h1;
  localparam logic [4:0] CHAIN_TICKS = 5'h1e;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  localparam logic [1:0] ADDR_PHASE = 2'h2;
  localparam int CTRL_OFF_BIT = 0;
  localparam int ST_REC = 0;
  localparam int ST_OVP = 1;
  localparam int ST_OPEN = 2;
  localparam int ST_CHAIN = 3;
  localparam int ST_EAMP = 4;
  localparam int ST_PG = 5;
  localparam int ST_BOOT = 6;
  localparam int ST_BMODE = 7;

  // ==========================================================================
  // Positions in the synchronised input vector
  // ==========================================================================
  localparam int NS = 32;
  localparam int I_EN_HI = 0;
  localparam int I_EN_LO = 1;
  localparam int I_VLOW = 2;
  localparam int I_OCP = 3;
  localparam int I_EAMP = 4;
  localparam int I_SS39 = 5;
  localparam int I_SSDEL = 6;
  localparam int I_SS02 = 7;
  localparam int I_SYSTEM_POWER_OK = 8;
  localparam int I_BHIGH = 9;
  localparam int I_OSC = 10;
  localparam int I_CHIN = 11;
  localparam int I_SCLK = 12;
  localparam int I_SDAT = 13;
  localparam int I_OVREF = 14;
  localparam int I_OVFIX = 16;
  localparam int I_DVID = 18;
  localparam int I_B200 = 20;
  localparam int I_OPEN = 22;
  localparam int I_UNDER = 24;
  localparam int I_SPECHI = 26;
  localparam int I_OTF = 28;
  localparam int I_INREG = 30;

  typedef enum logic [1:0] {CH_LAUNCH, CH_WAIT, CH_DEAD} rfs_chain_t;

  typedef struct packed {
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [NS-1:0] s3;
    logic rec;
    logic overvoltage_protect;
    logic open;
    logic chain_flt;
    logic eamp_flt;
    logic pg;
    logic boot_ok;
    logic [1:0] boot_code;
    logic boot_mode;
    logic boot_move;
    logic vid_off;
    logic [10:0] ocp_cnt;
    logic [3:0] eamp_cnt;
    rfs_chain_t ch;
    logic retry;
    logic ran;
    logic [4:0] ch_cnt;
    logic [4:0] phases;
    logic chain_out;
    logic [31:0] rdata;
  } rfs_state_t;

  localparam rfs_state_t ST_RESET = '0;

endpackage : rfs_pkg

// *** rfs_supervisor.sv ***
// Fault latches, regulation-ok pin, overvoltage alert and phase chain check.
// Assumes resetn is the power-on reset released by the gate drive supply.
//
// What this block does
// - Regulation-ok rises only with both outputs regulated and soft start above 3.9V.
// - Regulation-ok falls when enable is low or gate drive supply is below 86%.
// - Before regulation-ok, overcurrent for 1024 oscillator pulses trips the fault.
// - After regulation-ok, overcurrent trips only while soft start is below delay threshold.
// - Open chain, open sense line or output 315mV under reference drops regulation-ok.
// - Out-of-regulation alone drops regulation-ok but keeps both outputs regulating.
// - An output moving between two voltage codes is not out of spec.
// - Power-ok falling with enable high steers outputs to the stored boot code.
// - A higher boot code is no code transition; high out-of-spec drops regulation-ok.
// - Error amplifier saturated for 8 oscillator pulses sets a power-cycle latch.
// - Enable below its low threshold sets the recoverable fault latch.
// - Enable rising stores the 2 bit boot code, then releases soft start.
// - Output 240mV above reference latches overvoltage and pulls the amplifier low.
// - Latched overvoltage raises the oscillator pin and forces the share node.
// - The overvoltage latch clears only on a supply power cycle.
// - During downward code moves the fixed 1.6V threshold replaces reference plus 240mV.
// - Output below 200mV pulses test currents; comparator flags an open line.
// - Open sense latch pulls the amplifier low, discharges soft start, power-cycle only.
// - Power-up chain pulse waits 30 pulses, retries once, then latches a fault.
// - In operation a late chain pulse is relaunched; a second miss is a fault.
// - Phase count is taken from the return time of the chain pulse.
// - Recoverable fault discharges soft start and clears at 0.2V once causes are gone.
// - Software off command discharges soft start without dropping regulation-ok.
`timescale 1ns/100ps
module rfs_supervisor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic enable_above_high,
  input wire logic enable_below_low,
  input wire logic gate_drive_supply_low,
  input wire logic overcurrent,
  input wire logic error_amp_saturated,
  input wire logic softstart_above_pg,
  input wire logic softstart_above_delay,
  input wire logic softstart_below_reset,
  input wire logic system_power_ok,
  input wire logic boot_code_higher,
  input wire logic oscillator_pulse,
  input wire logic phase_chain_in,
  input wire logic serial_code_clock,
  input wire logic serial_code_data,
  input wire logic [1:0] overvoltage_ref,
  input wire logic [1:0] overvoltage_fixed,
  input wire logic [1:0] dynamic_down,
  input wire logic [1:0] sensed_output_below_200mv,
  input wire logic [1:0] sense_open_detect,
  input wire logic [1:0] sensed_output_under,
  input wire logic [1:0] sensed_output_spec_high,
  input wire logic [1:0] code_transition,
  input wire logic [1:0] sensed_output_in_reg,
  input wire logic [1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic regulation_ok_out,
  output logic regulation_ok_oe_n,
  output logic softstart_charge,
  output logic softstart_discharge,
  output logic error_amp_pull_low,
  output logic osc_overvoltage_pin,
  output logic current_share_node_force,
  output logic [1:0] sense_test_pulse,
  output logic phase_chain_out,
  output logic use_boot_code,
  output logic [1:0] boot_code
);
  import rfs_pkg::*;

  // ==========================================================================
  // Input gathering and derived terms
  // ==========================================================================
  rfs_state_t q;
  rfs_state_t n;
  logic [NS-1:0] raw;
  logic tick;
  logic ret;
  logic en_rise;
  logic pw_fall;
  logic pw_rise;
  logic perm;
  logic ocp_pre;
  logic ocp_post;
  logic rec_set;
  logic uv;
  logic sh;
  logic pg_drop;
  logic eamp_hit;
  logic timeout;
  logic open_hit;
  logic [1:0] otf_ok;
  logic [1:0] ovp_trip;

  assign raw = {sensed_output_in_reg, code_transition, sensed_output_spec_high,
                sensed_output_under, sense_open_detect, sensed_output_below_200mv,
                dynamic_down, overvoltage_fixed, overvoltage_ref, serial_code_data,
                serial_code_clock, phase_chain_in, oscillator_pulse, boot_code_higher,
                system_power_ok, softstart_below_reset, softstart_above_delay,
                softstart_above_pg, error_amp_saturated, overcurrent,
                gate_drive_supply_low, enable_below_low, enable_above_high};

  // Edges are taken between the second and third stages, never the first.
  assign tick = q.s2[I_OSC] & ~q.s3[I_OSC];
  assign ret = q.s2[I_CHIN] & ~q.s3[I_CHIN];
  assign en_rise = q.s2[I_EN_HI] & ~q.s3[I_EN_HI];
  assign pw_fall = ~q.s2[I_SYSTEM_POWER_OK] & q.s3[I_SYSTEM_POWER_OK];
  assign pw_rise = q.s2[I_SYSTEM_POWER_OK] & ~q.s3[I_SYSTEM_POWER_OK];
  assign perm = q.overvoltage_protect | q.open | q.chain_flt | q.eamp_flt;
  assign ocp_pre = tick & q.s2[I_OCP] & ~q.pg & (q.ocp_cnt == OCP_LAST);
  assign ocp_post = q.pg & q.s2[I_OCP] & ~q.s2[I_SSDEL];
  assign rec_set = q.s2[I_EN_LO] | q.s2[I_VLOW] | ocp_pre | ocp_post;
  // A higher boot code is a plain step, so the code-move excuse is withdrawn.
  assign otf_ok = q.s2[I_OTF +: 2] & {2{~q.boot_move}};
  assign uv = |(q.s2[I_UNDER +: 2] & ~otf_ok);
  assign sh = q.boot_move & (|q.s2[I_SPECHI +: 2]);
  // The set term keeps regulation-ok from rising in the very cycle a recoverable fault trips.
  assign pg_drop = ~q.s2[I_EN_HI] | q.s2[I_VLOW] | rec_set | q.rec | perm | uv | sh;
  assign eamp_hit = tick & q.s2[I_EAMP] & (q.eamp_cnt == EAMP_LAST);
  assign timeout = q.ran ? (q.ch_cnt > q.phases) : (q.ch_cnt == CHAIN_TICKS);
  assign open_hit = |(q.s2[I_B200 +: 2] & q.s2[I_OPEN +: 2]);
  // During a downward move the fixed level guards against false trips at light load.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ovp
      assign ovp_trip[gi] = q.s2[I_DVID + gi] ? q.s2[I_OVFIX + gi] : q.s2[I_OVREF + gi];
    end
  endgenerate

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    n = q;
    n.s1 = raw;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.chain_out = 1'b0;
    n.rdata = 32'h0000_0000;
    // Set wins over clear for the recoverable latch.
    if (rec_set) begin
      n.rec = 1'b1;
    end else if (q.rec && q.s2[I_SS02]) begin
      n.rec = 1'b0;
    end
    if (!q.s2[I_OCP] || q.pg) begin
      n.ocp_cnt = 11'h000;
    end else if (tick && q.ocp_cnt != OCP_LAST) begin
      n.ocp_cnt = q.ocp_cnt + 11'h001;
    end
    if (!q.s2[I_EAMP]) begin
      n.eamp_cnt = 4'h0;
    end else if (tick && q.eamp_cnt != EAMP_LAST) begin
      n.eamp_cnt = q.eamp_cnt + 4'h1;
    end
    // Power-cycle latches only ever set, here and in the chain check below; reset alone clears them.
    if (eamp_hit) begin
      n.eamp_flt = 1'b1;
    end
    if (|ovp_trip) begin
      n.overvoltage_protect = 1'b1;
    end
    if (open_hit) begin
      n.open = 1'b1;
    end
    if (pg_drop) begin
      n.pg = 1'b0;
    end else if ((&q.s2[I_INREG +: 2]) && q.s2[I_SS39] && q.boot_ok) begin
      n.pg = 1'b1;
    end
    if (!q.s2[I_EN_HI]) begin
      n.boot_ok = 1'b0;
    end else if (en_rise) begin
      n.boot_code = {q.s2[I_SCLK], q.s2[I_SDAT]};
      n.boot_ok = 1'b1;
    end
    if (!q.s2[I_EN_HI] || pw_rise) begin
      n.boot_mode = 1'b0;
      n.boot_move = 1'b0;
    end else if (pw_fall) begin
      n.boot_mode = 1'b1;
      n.boot_move = q.s2[I_BHIGH];
    end
    case (q.ch)
      CH_LAUNCH: begin
        if (tick) begin
          n.chain_out = 1'b1;
          n.ch_cnt = 5'h00;
          n.ch = CH_WAIT;
        end
      end
      CH_WAIT: begin
        if (ret) begin
          n.phases = q.ch_cnt;
          n.ran = 1'b1;
          n.retry = 1'b0;
          n.ch = CH_LAUNCH;
        end else if (tick && timeout) begin
          if (q.retry) begin
            n.chain_flt = 1'b1;
            n.ch = CH_DEAD;
          end else begin
            n.retry = 1'b1;
            n.ch = CH_LAUNCH;
          end
        end else if (tick) begin
          n.ch_cnt = q.ch_cnt + 5'h01;
        end
      end
      CH_DEAD: begin
        n.ch = CH_DEAD;
      end
      default: begin
        n.ch = CH_LAUNCH;
      end
    endcase
    if (reg_wr && reg_addr == ADDR_CTRL) begin
      n.vid_off = reg_wdata[CTRL_OFF_BIT];
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: n.rdata[CTRL_OFF_BIT] = q.vid_off;
        ADDR_STAT: n.rdata[7:0] = {q.boot_mode, q.boot_ok, q.pg, q.eamp_flt,
                                   q.chain_flt, q.open, q.overvoltage_protect, q.rec};
        ADDR_PHASE: n.rdata[4:0] = q.phases;
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= ST_RESET;
    end else begin
      q <= n;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // The pin only ever pulls low; the pull-up resistor makes the high level.
  assign regulation_ok_out = 1'b0;
  assign regulation_ok_oe_n = q.pg;
  assign softstart_charge = q.boot_ok & q.s2[I_EN_HI] & ~q.rec & ~perm & ~q.vid_off;
  // Voltage-code off shuts the stage down but is not a fault for regulation-ok.
  assign softstart_discharge = q.rec | perm | q.vid_off;
  assign error_amp_pull_low = q.rec | perm | q.vid_off;
  assign osc_overvoltage_pin = q.overvoltage_protect;
  assign current_share_node_force = q.overvoltage_protect;
  assign sense_test_pulse = q.s2[I_B200 +: 2] & {2{q.s2[I_OSC]}};
  assign phase_chain_out = q.chain_out;
  assign use_boot_code = q.boot_mode;
  assign boot_code = q.boot_code;
  assign reg_rdata = q.rdata;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_eamp_full;
    tick && q.s2[I_EAMP] && q.eamp_cnt == EAMP_LAST;
  endsequence
  sequence s_second_miss;
    q.ch == CH_WAIT && q.retry && tick && timeout && !ret;
  endsequence

  pg_rise_cause_a: assert property ($rose(q.pg) |-> $past(q.s2[I_SS39]) &&
    $past(&q.s2[I_INREG +: 2])) else $error("regulation ok rose too early");
  pg_enable_a: assert property (!q.s2[I_EN_HI] |=> !q.pg)
    else $error("regulation ok held with enable low");
  ocp_pre_a: assert property (ocp_pre |=> q.rec && !q.pg)
    else $error("overcurrent count did not trip");
  ocp_post_a: assert property (ocp_post |=> q.rec ##1 !q.pg)
    else $error("overcurrent after ok did not trip");
  uv_drop_a: assert property (q.pg && uv |=> !q.pg)
    else $error("under reference kept regulation ok");
  uv_keep_a: assert property (q.pg && uv && !q.rec && !q.s2[I_OCP] &&
    !q.s2[I_EN_LO] && !q.s2[I_VLOW] |=> !q.rec && !softstart_discharge || perm || q.vid_off)
    else $error("out of regulation shut down");
  otf_excuse_a: assert property (!q.boot_move &&
    (q.s2[I_UNDER +: 2] & ~q.s2[I_OTF +: 2]) == 2'h0 |-> !uv)
    else $error("code move treated as out of spec");
  boot_mode_a: assert property (pw_fall && q.s2[I_EN_HI] |=> use_boot_code)
    else $error("boot code not selected");
  eamp_fault_a: assert property (s_eamp_full |=> q.eamp_flt [*2])
    else $error("saturation fault not latched");
  boot_store_a: assert property (en_rise |=>
    boot_code == $past({q.s2[I_SCLK], q.s2[I_SDAT]})) else $error("boot code wrong");
  ovp_hold_a: assert property (q.overvoltage_protect |=> q.overvoltage_protect && osc_overvoltage_pin &&
    current_share_node_force && error_amp_pull_low) else $error("overvoltage released");
  open_line_a: assert property (open_hit |=> q.open && softstart_discharge)
    else $error("open sense not latched");
  chain_fault_a: assert property (s_second_miss |=> q.chain_flt && !softstart_charge)
    else $error("open chain not registered");
  off_keep_a: assert property (q.pg && q.vid_off && q.s2[I_EN_HI] && !q.s2[I_VLOW] &&
    !q.s2[I_OCP] && !q.s2[I_EN_LO] && !q.rec && !perm && !uv && !sh |=> q.pg)
    else $error("off command dropped regulation ok");

endmodule : rfs_supervisor

// *** rfs_supervisor_tb.sv ***
// Self-checking bench of the regulator fault supervisor beside its phase chain partner.
// Assumes rfs_pkg, rfs_supervisor and rfs_phase_model are compiled before it.
`timescale 1ns/100ps
module rfs_supervisor_tb;
  import rfs_pkg::*;
  logic clk, resetn, enable_above_high, enable_below_low, gate_drive_supply_low, overcurrent;
  logic error_amp_saturated, softstart_above_pg, softstart_above_delay, softstart_below_reset;
  logic system_power_ok, boot_code_higher, oscillator_pulse, phase_chain_in, reg_wr, reg_rd;
  logic serial_code_clock, serial_code_data, chain_open, low_side_on, use_boot_code;
  logic [1:0] overvoltage_ref, overvoltage_fixed, dynamic_down, sensed_output_below_200mv;
  logic [1:0] sense_open_detect, sensed_output_under, sensed_output_spec_high, code;
  logic [1:0] code_transition, sensed_output_in_reg, reg_addr, sense_test_pulse, boot_code;
  logic [31:0] reg_wdata, reg_rdata, rd_v, rnd;
  logic regulation_ok_out, regulation_ok_oe_n, softstart_charge, softstart_discharge;
  logic error_amp_pull_low, osc_overvoltage_pin, current_share_node_force, phase_chain_out;
  logic [4:0] n_phases;
  int n_fail, checks, seen;

  rfs_supervisor DUT (.clk, .resetn, .enable_above_high, .enable_below_low,
    .gate_drive_supply_low, .overcurrent, .error_amp_saturated, .softstart_above_pg,
    .softstart_above_delay, .softstart_below_reset, .system_power_ok, .boot_code_higher,
    .oscillator_pulse, .phase_chain_in, .serial_code_clock, .serial_code_data,
    .overvoltage_ref, .overvoltage_fixed, .dynamic_down, .sensed_output_below_200mv,
    .sense_open_detect, .sensed_output_under, .sensed_output_spec_high, .code_transition,
    .sensed_output_in_reg, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .regulation_ok_out, .regulation_ok_oe_n, .softstart_charge, .softstart_discharge,
    .error_amp_pull_low, .osc_overvoltage_pin, .current_share_node_force, .sense_test_pulse,
    .phase_chain_out, .use_boot_code, .boot_code);
  rfs_phase_model partner (.clk, .resetn, .phase_chain_out, .current_share_node_force,
    .n_phases, .chain_open, .oscillator_pulse, .phase_chain_in, .low_side_on);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic ck1(input string what, input logic got, input logic exp);
    chk(what, {31'h0, got}, {31'h0, exp});
  endtask : ck1
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic ticks(input int n);
    repeat (n) @(posedge oscillator_pulse);
    @(posedge clk);
  endtask : ticks
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
  task automatic rd(input logic [1:0] a);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 rd_v = reg_rdata;
  endtask : rd
  task automatic st(input int b, input logic exp, input string what);
    rd(ADDR_STAT);
    ck1(what, rd_v[b], exp);
  endtask : st
  // The recoverable latch needs the soft start node low with every cause gone.
  task automatic relax();
    softstart_below_reset <= 1'h1;
    cyc(6);
    softstart_below_reset <= 1'h0;
    cyc(8);
  endtask : relax
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // About 1300 ticks of eight clocks are needed; the limit leaves ample room.
  initial begin
    cyc(40000);
    n_fail++;
    wrap_up();
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    n_fail = 0;
    checks = 0;
    rnd = 32'h0001_101a;
    resetn = 1'h0;
    {enable_above_high, enable_below_low, gate_drive_supply_low, overcurrent} = 4'h0;
    {error_amp_saturated, softstart_above_pg, softstart_above_delay} = 3'h0;
    {softstart_below_reset, system_power_ok, boot_code_higher, reg_wr, reg_rd} = 5'h00;
    {serial_code_clock, serial_code_data, chain_open, reg_addr, reg_wdata} = '0;
    {overvoltage_ref, overvoltage_fixed, dynamic_down, sensed_output_below_200mv} = 8'h00;
    {sense_open_detect, sensed_output_under, sensed_output_spec_high} = 6'h00;
    {code_transition, sensed_output_in_reg} = 4'h0;
    rnd = xs(rnd);
    n_phases = 5'h02 + 5'(rnd[7:0] % 5);
    code = rnd[9:8];
    cyc(16);
    resetn <= 1'h1;
    cyc(2);
    ck1("pg after reset", regulation_ok_oe_n, 1'h0);
    ck1("pg pin level", regulation_ok_out, 1'h0);
    rd(ADDR_STAT);
    chk("status reset", rd_v, 32'h0000_0000);
    rd(2'h3);
    chk("unmapped read", rd_v, 32'h0000_0000);
    serial_code_clock <= code[1];
    serial_code_data <= code[0];
    enable_above_high <= 1'h1;
    cyc(8);
    serial_code_clock <= ~code[1];
    serial_code_data <= ~code[0];
    cyc(8);
    chk("boot code", 32'(boot_code), 32'(code));
    ticks(3 * n_phases + 40);
    rd(ADDR_PHASE);
    chk("phase count", rd_v, 32'(n_phases));
    $display("test power up done");
    overcurrent <= 1'h1;
    ticks(1000);
    st(ST_REC, 1'h0, "ocp early");
    ticks(40);
    st(ST_REC, 1'h1, "ocp long");
    ck1("fault discharge", softstart_discharge, 1'h1);
    overcurrent <= 1'h0;
    relax();
    st(ST_REC, 1'h0, "rec cleared");
    $display("test early overcurrent done");
    sensed_output_in_reg <= 2'h3;
    softstart_above_delay <= 1'h1;
    cyc(8);
    ck1("pg soft start", regulation_ok_oe_n, 1'h0);
    softstart_above_pg <= 1'h1;
    cyc(8);
    ck1("pg up", regulation_ok_oe_n, 1'h1);
    code_transition <= 2'h2;
    sensed_output_under <= 2'h2;
    cyc(8);
    ck1("pg moving", regulation_ok_oe_n, 1'h1);
    code_transition <= 2'h0;
    cyc(8);
    ck1("pg under", regulation_ok_oe_n, 1'h0);
    ck1("still running", softstart_discharge | error_amp_pull_low, 1'h0);
    sensed_output_under <= 2'h0;
    cyc(8);
    ck1("pg back", regulation_ok_oe_n, 1'h1);
    wr(ADDR_CTRL, 32'h0000_0001);
    cyc(2);
    chk("off", {softstart_discharge, error_amp_pull_low, regulation_ok_oe_n}, 3'h7);
    wr(ADDR_CTRL, 32'h0000_0000);
    cyc(2);
    ck1("on again", softstart_discharge, 1'h0);
    $display("test regulation ok done");
    overcurrent <= 1'h1;
    cyc(40);
    ck1("ocp delayed", regulation_ok_oe_n, 1'h1);
    softstart_above_delay <= 1'h0;
    cyc(8);
    ck1("ocp trip", regulation_ok_oe_n, 1'h0);
    overcurrent <= 1'h0;
    softstart_above_delay <= 1'h1;
    relax();
    for (int i = 0; i < 2; i++) begin
      cyc(8);
      ck1("pg ready", regulation_ok_oe_n, 1'h1);
      if (i == 0) gate_drive_supply_low <= 1'h1;
      else enable_below_low <= 1'h1;
      cyc(8);
      ck1("pg cause", regulation_ok_oe_n, 1'h0);
      st(ST_REC, 1'h1, "rec cause");
      {gate_drive_supply_low, enable_below_low} <= 2'h0;
      relax();
    end
    $display("test recoverable faults done");
    system_power_ok <= 1'h1;
    cyc(8);
    system_power_ok <= 1'h0;
    boot_code_higher <= 1'h1;
    cyc(8);
    ck1("boot steer", use_boot_code, 1'h1);
    sensed_output_spec_high <= 2'h1;
    cyc(8);
    ck1("pg spec high", regulation_ok_oe_n, 1'h0);
    {boot_code_higher, sensed_output_spec_high} <= 3'h0;
    $display("test boot steer done");
    error_amp_saturated <= 1'h1;
    ticks(rnd[10] ? 4 : 3);
    error_amp_saturated <= 1'h0;
    st(ST_EAMP, 1'h0, "eamp short");
    error_amp_saturated <= 1'h1;
    ticks(11);
    error_amp_saturated <= 1'h0;
    st(ST_EAMP, 1'h1, "eamp long");
    dynamic_down <= 2'h1;
    overvoltage_ref <= 2'h1;
    cyc(8);
    ck1("ovp masked", osc_overvoltage_pin, 1'h0);
    overvoltage_fixed <= 2'h1;
    cyc(8);
    {dynamic_down, overvoltage_ref, overvoltage_fixed} <= 6'h00;
    enable_below_low <= 1'h1;
    cyc(8);
    enable_below_low <= 1'h0;
    relax();
    st(ST_EAMP, 1'h1, "eamp kept");
    chk("ovp held", {osc_overvoltage_pin, current_share_node_force, low_side_on}, 3'h7);
    $display("test latched faults done");
    sensed_output_below_200mv <= 2'h2;
    seen = 0;
    repeat (24) begin
      @(posedge clk);
      seen += int'(sense_test_pulse[1]);
    end
    ck1("test pulse", seen != 0, 1'h1);
    ck1("test pulse quiet", sense_test_pulse[0], 1'h0);
    sense_open_detect <= 2'h2;
    cyc(8);
    st(ST_OPEN, 1'h1, "open line");
    chain_open <= 1'h1;
    ticks(3 * n_phases + 10);
    st(ST_CHAIN, 1'h1, "chain lost");
    $display("test sense and chain done");
    {sensed_output_below_200mv, sense_open_detect} <= 4'h0;
    resetn <= 1'h0;
    cyc(16);
    resetn <= 1'h1;
    cyc(4);
    ck1("ovp cleared", osc_overvoltage_pin, 1'h0);
    ticks(45);
    st(ST_CHAIN, 1'h0, "chain retry");
    ticks(25);
    st(ST_CHAIN, 1'h1, "chain dead");
    ck1("no charge", softstart_charge, 1'h0);
    overvoltage_ref <= 2'h2;
    cyc(8);
    chk("ovp alert", {osc_overvoltage_pin, current_share_node_force, error_amp_pull_low}, 3'h7);
    $display("test power cycle done");
    wrap_up();
  end
endmodule : rfs_supervisor_tb
